/* design/quad_serial_flash_cmd_decoder.sv */
/*
  Instruction decoder of a serial NOR flash: link side on sclk, state on ref_clk.
  Assumes the host keeps cs_n high at least 4 ref_clk cycles between frames and
  that the array read port answers combinationally on the link clock.
*/
// Operation
// - Four-bit mode: nibble per clock, upper first
// - All fields travel most significant bit first
// - Write-enable opcode sets the latch
// - Volatile enable and write-disable decoded
// - Status reads repeat chosen byte until deselect
// - Status writes to 31h and 11h take one data byte
// - Two bytes after 01h write low and mid
// - Chip erase, suspend, resume, power-down decoded
// - Parameter upper nibble sets dummy clocks
// - Wrap read length from parameter lower nibble
// - Release opcode: three dummies, repeating part code
// - ID read: three input bytes, maker then part
// - Block lock commands and lock byte read
// - Page program wraps within 256 bytes
// - Word read: two idle clocks, then data
// - Security register chosen by middle address byte
// - Dual lanes: odd bit IO1, even IO0
// - Quad data: bits 7..4 then 3..0
`timescale 1ns/10ps
`include "flash_cmd_params.svh"
module quad_serial_flash_cmd_decoder #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_CODE_HI = 8'h71 // Arbitrary value
) (
  // System clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // Array read port, link clock
  output logic [23:0] arr_addr,
  input wire logic [7:0] arr_data,
  input wire logic [7:0] lock_state_byte,
  // Command hand-off, ref clock
  input wire logic array_busy,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [23:0] cmd_addr,
  output logic [8:0] cmd_data_len,
  output logic [1:0] sec_reg_sel,
  input wire logic [7:0] pg_rd_addr,
  output logic [7:0] pg_rd_data,
  output logic dev_reset,
  // Device state
  output logic write_enable_latch,
  output logic four_bit_instruction_mode,
  output logic power_down,
  output logic [7:0] status_low_byte,
  output logic [7:0] status_mid_byte,
  output logic [7:0] status_high_byte,
  output logic [7:0] read_parameter_byte
);

  // Link side state
  logic frame_rst_n; // Frame ends the moment cs_n rises
  logic started_reg; // Seen a clock in this frame
  flash_cmd_pkg::phase_t phase_reg, ph;
  logic [2:0] bitc_reg, bc, lw, tx_pos_reg;
  logic [3:0] bsum, tsum, dcnt_reg, dcf;
  logic byte_done;
  logic [7:0] sh_reg, sh_next, opcode_reg, d0_reg, d1_reg, tx_byte, tx_sh;
  logic [23:0] addr_reg, wrap_mask, addr_inc;
  logic [1:0] nbyte_reg;
  logic [8:0] ndata_reg;
  logic frame_tog_reg; // Flips once per decoded opcode
  logic [7:0] page_mem [0:255]; // Page program data
  logic [3:0] io_out_reg;
  logic [3:0] io_oe_reg;
  // Ref side state
  logic cs_meta_reg, cs_sync_reg, cs_prev_reg, seen_tog_reg, commit;
  logic wel_reg, vol_en_reg, four_bit_reg, pd_reg, arm_reg;
  logic [7:0] sts_low_reg, sts_mid_reg, sts_high_reg, rparam_reg;

  assign frame_rst_n = rst_n & ~cs_n;
  assign dcf = rparam_reg[7:4]; // Dummy clock count field, quiet during frames

  // Dummy clocks after the address or mode byte
  function automatic logic [3:0] dummy_for(input logic [7:0] o, input logic [3:0] f);
    case (o)
      `OP_FREAD, `OP_WRAP_RD, `OP_QIO_RD: dummy_for = f;
      `OP_WORD_RD: dummy_for = `WORD_RD_IDLE;
      default: dummy_for = 4'h0;
    endcase
  endfunction

  // Phase after the opcode byte
  function automatic flash_cmd_pkg::phase_t after_opc(input logic [7:0] o);
    case (o)
      `OP_PP, `OP_QPP, `OP_SE, `OP_BE32, `OP_BE64, `OP_FREAD, `OP_WRAP_RD, `OP_QIO_RD,
      `OP_WORD_RD, `OP_OCT_RD, `OP_DIO_RD, `OP_LOCK, `OP_UNLOCK, `OP_RD_LOCK,
      `OP_SEC_ER, `OP_SEC_PG: after_opc = flash_cmd_pkg::PH_ADDR;
      `OP_WRSR1, `OP_WRSR2, `OP_WRSR3, `OP_SETP, `OP_RELPD,
      `OP_MFID: after_opc = flash_cmd_pkg::PH_DIN;
      `OP_RDSR1, `OP_RDSR2, `OP_RDSR3, `OP_JEDEC: after_opc = flash_cmd_pkg::PH_DOUT;
      default: after_opc = flash_cmd_pkg::PH_SKIP; // Opcode-only commands
    endcase
  endfunction

  // Phase after the last address byte
  function automatic flash_cmd_pkg::phase_t after_addr(input logic [7:0] o,
                                                       input logic [3:0] f);
    case (o)
      `OP_FREAD, `OP_WRAP_RD:
        after_addr = (f == 4'h0) ? flash_cmd_pkg::PH_DOUT : flash_cmd_pkg::PH_DUMMY;
      `OP_QIO_RD, `OP_WORD_RD, `OP_OCT_RD, `OP_DIO_RD: after_addr = flash_cmd_pkg::PH_MODE;
      `OP_RD_LOCK: after_addr = flash_cmd_pkg::PH_DOUT;
      `OP_PP, `OP_QPP, `OP_SEC_PG: after_addr = flash_cmd_pkg::PH_DIN;
      default: after_addr = flash_cmd_pkg::PH_SKIP;
    endcase
  endfunction

  // Lane width and bit assembly of the current clock
  always_comb begin
    ph = started_reg ? phase_reg : flash_cmd_pkg::PH_OPC;
    bc = started_reg ? bitc_reg : 3'h0;
    if (four_bit_reg) begin
      lw = 3'h4;
    end else if (ph == flash_cmd_pkg::PH_OPC) begin
      lw = 3'h1;
    end else begin
      case (opcode_reg)
        `OP_DIO_RD: lw = 3'h2;
        `OP_QIO_RD, `OP_WORD_RD, `OP_OCT_RD, `OP_QPP: lw = 3'h4;
        default: lw = 3'h1;
      endcase
    end
    // Earlier bits move up, so the first bit lands highest
    case (lw)
      3'h4: sh_next = {sh_reg[3:0], io_in};
      3'h2: sh_next = {sh_reg[5:0], io_in[1], io_in[0]};
      default: sh_next = {sh_reg[6:0], io_in[0]};
    endcase
    bsum = {1'b0, bc} + {1'b0, lw};
    byte_done = bsum[3];
    tsum = {1'b0, tx_pos_reg} + {1'b0, lw};
  end

  // Byte to send and address step
  always_comb begin
    case (opcode_reg)
      `OP_RDSR1: tx_byte = status_low_byte;
      `OP_RDSR2: tx_byte = sts_mid_reg;
      `OP_RDSR3: tx_byte = sts_high_reg;
      `OP_RELPD: tx_byte = PART_CODE;
      `OP_MFID: tx_byte = nbyte_reg[0] ? PART_CODE : MAKER_CODE;
      `OP_JEDEC: tx_byte = (nbyte_reg == 2'h0) ? MAKER_CODE :
                           (nbyte_reg == 2'h1) ? PART_CODE_HI : PART_CODE;
      `OP_RD_LOCK: tx_byte = lock_state_byte;
      default: tx_byte = arr_data;
    endcase
    tx_sh = tx_byte << tx_pos_reg;
    // Wrap length 8, 16, 32 or 64 bytes from the low field bits
    wrap_mask = (24'h000008 << rparam_reg[1:0]) - 24'h000001;
    if (opcode_reg == `OP_WRAP_RD) begin
      addr_inc = (addr_reg & ~wrap_mask) | ((addr_reg + 24'h000001) & wrap_mask);
    end else begin
      addr_inc = addr_reg + 24'h000001;
    end
  end

  // Frame start marker, cleared by deselect
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  // Phase sequencing on rising edges
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= flash_cmd_pkg::PH_OPC;
      bitc_reg <= 3'h0;
      nbyte_reg <= 2'h0;
      ndata_reg <= 9'h000;
      dcnt_reg <= 4'h0;
      tx_pos_reg <= 3'h0;
    end else begin
      // Dummy and output clocks carry no input bits
      if (byte_done || ph == flash_cmd_pkg::PH_DUMMY || ph == flash_cmd_pkg::PH_DOUT) begin
        bitc_reg <= 3'h0;
      end else begin
        bitc_reg <= bsum[2:0];
      end
      if (ph != flash_cmd_pkg::PH_DOUT) begin
        tx_pos_reg <= 3'h0;
      end
      unique case (ph)
        flash_cmd_pkg::PH_OPC: begin
          phase_reg <= flash_cmd_pkg::PH_OPC;
          nbyte_reg <= 2'h0;
          ndata_reg <= 9'h000;
          if (byte_done) begin
            // Asleep, only the release opcode is heard
            phase_reg <= (pd_reg && sh_next != `OP_RELPD) ? flash_cmd_pkg::PH_SKIP :
                         after_opc(sh_next);
          end
        end
        flash_cmd_pkg::PH_ADDR: if (byte_done) begin
          nbyte_reg <= nbyte_reg + 2'h1;
          if (nbyte_reg == `ADDR_LAST) begin
            nbyte_reg <= 2'h0;
            phase_reg <= after_addr(opcode_reg, dcf);
            dcnt_reg <= dummy_for(opcode_reg, dcf);
          end
        end
        flash_cmd_pkg::PH_MODE: if (byte_done) begin
          dcnt_reg <= dummy_for(opcode_reg, dcf);
          phase_reg <= (dummy_for(opcode_reg, dcf) == 4'h0) ? flash_cmd_pkg::PH_DOUT :
                       flash_cmd_pkg::PH_DUMMY;
        end
        flash_cmd_pkg::PH_DUMMY: begin
          dcnt_reg <= dcnt_reg - 4'h1;
          if (dcnt_reg == 4'h1) begin
            phase_reg <= flash_cmd_pkg::PH_DOUT;
          end
        end
        flash_cmd_pkg::PH_DIN: if (byte_done) begin
          if (ndata_reg != `DATA_LEN_MAX) begin
            ndata_reg <= ndata_reg + 9'h001;
          end
          // Release and ID reads answer after three input bytes
          if ((opcode_reg == `OP_RELPD || opcode_reg == `OP_MFID) &&
              ndata_reg == `IN_DUMMY_LAST) begin
            phase_reg <= flash_cmd_pkg::PH_DOUT;
            nbyte_reg <= 2'h0;
          end
        end
        flash_cmd_pkg::PH_DOUT: begin
          if (tsum[3]) begin
            tx_pos_reg <= 3'h0;
            nbyte_reg <= (opcode_reg == `OP_JEDEC && nbyte_reg == `JEDEC_LAST) ? 2'h0 :
                         nbyte_reg + 2'h1;
          end else begin
            tx_pos_reg <= tsum[2:0];
          end
        end
        flash_cmd_pkg::PH_SKIP: phase_reg <= flash_cmd_pkg::PH_SKIP;
        default: phase_reg <= flash_cmd_pkg::PH_SKIP;
      endcase
    end
  end

  // Opcode, address and data capture
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg <= 8'h00;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      d0_reg <= 8'h00;
      d1_reg <= 8'h00;
      frame_tog_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      if (ph == flash_cmd_pkg::PH_OPC && byte_done) begin
        opcode_reg <= sh_next;
        // Asleep, a refused opcode must not reach the commit
        frame_tog_reg <= frame_tog_reg ^ (!pd_reg || sh_next == `OP_RELPD);
      end
      if (ph == flash_cmd_pkg::PH_ADDR && byte_done) begin
        addr_reg <= {addr_reg[15:0], sh_next};
      end
      if (ph == flash_cmd_pkg::PH_DIN && byte_done && ndata_reg == 9'h000) begin
        d0_reg <= sh_next;
      end
      if (ph == flash_cmd_pkg::PH_DIN && byte_done && ndata_reg == 9'h001) begin
        d1_reg <= sh_next;
      end
      // Array reads walk the address after each byte
      if (ph == flash_cmd_pkg::PH_DOUT && tsum[3] && opcode_reg != `OP_RD_LOCK) begin
        addr_reg <= addr_inc;
      end
    end
  end

  // Page buffer; index wraps inside the page, later bytes overwrite
  always_ff @(posedge sclk) begin
    if (ph == flash_cmd_pkg::PH_DIN && byte_done &&
        (opcode_reg == `OP_PP || opcode_reg == `OP_QPP || opcode_reg == `OP_SEC_PG)) begin
      page_mem[addr_reg[7:0] + ndata_reg[7:0]] <= sh_next;
    end
  end

  // Drive on falling edges so the host samples on the next rising edge
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      io_oe_reg <= 4'h0;
      io_out_reg <= 4'h0;
    end else if (started_reg && phase_reg == flash_cmd_pkg::PH_DOUT) begin
      case (lw)
        3'h4: begin
          io_oe_reg <= 4'hF;
          io_out_reg <= tx_sh[7:4];
        end
        3'h2: begin
          io_oe_reg <= 4'h3;
          io_out_reg <= {2'h0, tx_sh[7:6]};
        end
        default: begin
          io_oe_reg <= 4'h2; // Single-bit data leaves on IO1
          io_out_reg <= {2'h0, tx_sh[7], 1'b0};
        end
      endcase
    end else begin
      io_oe_reg <= 4'h0; // Lines float through dummy clocks
      io_out_reg <= 4'h0;
    end
  end

  // Deselect crossing; link words are still once cs_n is high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      seen_tog_reg <= 1'b0;
    end else begin
      cs_meta_reg <= cs_n;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      if (commit) begin
        seen_tog_reg <= frame_tog_reg;
      end
    end
  end
  // A frame without a whole opcode commits nothing
  assign commit = cs_sync_reg & ~cs_prev_reg & (frame_tog_reg != seen_tog_reg);

  // Status, parameters and mode updates at frame end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_reg <= 1'b0;
      vol_en_reg <= 1'b0;
      four_bit_reg <= 1'b0;
      pd_reg <= 1'b0;
      arm_reg <= 1'b0;
      sts_low_reg <= `STS_RST;
      sts_mid_reg <= `STS_RST;
      sts_high_reg <= `STS_RST;
      rparam_reg <= `RD_PARAM_RST;
      dev_reset <= 1'b0;
    end else begin
      dev_reset <= 1'b0;
      if (commit) begin
        arm_reg <= (opcode_reg == `OP_RST_EN);
        vol_en_reg <= (opcode_reg == `OP_VWREN);
        case (opcode_reg)
          `OP_WREN: wel_reg <= 1'b1;
          `OP_WRDI: wel_reg <= 1'b0;
          `OP_WRSR1, `OP_WRSR2, `OP_WRSR3:
            if ((wel_reg || vol_en_reg) && ndata_reg != 9'h000) begin
            wel_reg <= 1'b0;
            if (opcode_reg == `OP_WRSR1) begin
              sts_low_reg <= d0_reg;
            end
            if (opcode_reg == `OP_WRSR1 && ndata_reg == 9'h002) begin
              sts_mid_reg <= d1_reg;
            end
            if (opcode_reg == `OP_WRSR2) begin
              sts_mid_reg <= d0_reg;
            end
            if (opcode_reg == `OP_WRSR3) begin
              sts_high_reg <= d0_reg;
            end
          end
          `OP_SETP: if (ndata_reg != 9'h000) begin
            rparam_reg <= d0_reg;
          end
          `OP_MODE_ENTER: four_bit_reg <= 1'b1;
          `OP_MODE_EXIT: four_bit_reg <= 1'b0;
          `OP_PDOWN: pd_reg <= 1'b1;
          `OP_RELPD: pd_reg <= 1'b0;
          `OP_PP, `OP_QPP, `OP_SE, `OP_BE32, `OP_BE64, `OP_CE1, `OP_CE2,
          `OP_SEC_ER, `OP_SEC_PG: wel_reg <= 1'b0;
          `OP_RST_DEV: if (arm_reg) begin
            wel_reg <= 1'b0;
            four_bit_reg <= 1'b0;
            pd_reg <= 1'b0;
            sts_low_reg <= `STS_RST;
            sts_mid_reg <= `STS_RST;
            sts_high_reg <= `STS_RST;
            rparam_reg <= `RD_PARAM_RST;
            dev_reset <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Array command hand-off; unlatched program or erase is dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid <= 1'b0;
      cmd_opcode <= 8'h00;
      cmd_addr <= 24'h000000;
      cmd_data_len <= 9'h000;
      sec_reg_sel <= 2'h0;
      pg_rd_data <= 8'h00;
    end else begin
      pg_rd_data <= page_mem[pg_rd_addr];
      cmd_valid <= 1'b0;
      if (commit) begin
        cmd_opcode <= opcode_reg;
        cmd_addr <= addr_reg;
        cmd_data_len <= ndata_reg;
        sec_reg_sel <= 2'h0;
        if (addr_reg[23:16] == `SEC_UPPER) begin
          sec_reg_sel <= (addr_reg[15:8] == `SEC1_MID) ? 2'h1 :
                         (addr_reg[15:8] == `SEC2_MID) ? 2'h2 :
                         (addr_reg[15:8] == `SEC3_MID) ? 2'h3 : 2'h0;
        end
        case (opcode_reg)
          `OP_PP, `OP_QPP, `OP_SEC_PG: cmd_valid <= wel_reg && ndata_reg != 9'h000;
          `OP_SE, `OP_BE32, `OP_BE64, `OP_CE1, `OP_CE2,
          `OP_SEC_ER: cmd_valid <= wel_reg;
          `OP_SUSP, `OP_RESUME, `OP_GLOCK, `OP_GUNLOCK, `OP_LOCK,
          `OP_UNLOCK: cmd_valid <= 1'b1;
          default: cmd_valid <= 1'b0;
        endcase
      end
    end
  end

  assign io_out = io_out_reg;
  assign io_oe = io_oe_reg;
  assign arr_addr = addr_reg;
  assign write_enable_latch = wel_reg;
  assign four_bit_instruction_mode = four_bit_reg;
  assign power_down = pd_reg;
  assign status_low_byte = {sts_low_reg[7:2], wel_reg, array_busy};
  assign status_mid_byte = sts_mid_reg;
  assign status_high_byte = sts_high_reg;
  assign read_parameter_byte = rparam_reg;

endmodule

/* design/flash_cmd_params.svh */
/*
  Opcodes, field positions and reset values of the serial flash command decoder.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// Single-byte commands
`define OP_WREN 8'h06
`define OP_VWREN 8'h50
`define OP_WRDI 8'h04
`define OP_CE1 8'hC7
`define OP_CE2 8'h60
`define OP_SUSP 8'h75
`define OP_RESUME 8'h7A
`define OP_PDOWN 8'hB9
`define OP_GLOCK 8'h7E
`define OP_GUNLOCK 8'h98
`define OP_MODE_EXIT 8'hFF
`define OP_MODE_ENTER 8'h38
`define OP_RST_EN 8'h66
`define OP_RST_DEV 8'h99
// Status access
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_RDSR3 8'h15
`define OP_WRSR1 8'h01
`define OP_WRSR2 8'h31
`define OP_WRSR3 8'h11
`define OP_SETP 8'hC0
// Identity reads
`define OP_RELPD 8'hAB
`define OP_MFID 8'h90
`define OP_JEDEC 8'h9F
// Address commands
`define OP_PP 8'h02
`define OP_QPP 8'h32
`define OP_SE 8'h20
`define OP_BE32 8'h52
`define OP_BE64 8'hD8
`define OP_SEC_ER 8'h44
`define OP_SEC_PG 8'h42
`define OP_LOCK 8'h36
`define OP_UNLOCK 8'h39
`define OP_RD_LOCK 8'h3D
// Reads
`define OP_FREAD 8'h0B
`define OP_WRAP_RD 8'h0C
`define OP_QIO_RD 8'hEB
`define OP_WORD_RD 8'hE7
`define OP_OCT_RD 8'hE3
`define OP_DIO_RD 8'hBB

// Status layout and reset values
`define STS_BUSY_BIT 0
`define STS_LATCH_BIT 1
`define STS_RST 8'h00
`define RD_PARAM_RST 8'h40
// Idle clocks of word read and last index of fixed byte groups
`define WORD_RD_IDLE 4'h2
`define ADDR_LAST 2'h2
`define IN_DUMMY_LAST 9'h002
`define JEDEC_LAST 2'h2
// Security register selectors in the middle address byte
`define SEC_UPPER 8'h00
`define SEC1_MID 8'h10
`define SEC2_MID 8'h20
`define SEC3_MID 8'h30
`define DATA_LEN_MAX 9'h1FF

`endif

/* design/flash_cmd_pkg.sv */
/*
  Types of the serial flash command decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flash_cmd_pkg;
  // Frame phase on the link clock
  typedef enum logic [2:0] {
    PH_OPC = 3'h0,
    PH_ADDR = 3'h1,
    PH_MODE = 3'h2,
    PH_DUMMY = 3'h3,
    PH_DIN = 3'h4,
    PH_DOUT = 3'h5,
    PH_SKIP = 3'h6
  } phase_t;
endpackage

/* testbench/flash_host_model.sv */
/*
  Host model: drives link clock, frame select and IO lines, reads answers.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/10ps
module flash_host_model (
  // Link outputs
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in,
  // Device lines
  input wire logic [3:0] io_out
);
  // Lanes per clock, 1, 2 or 4
  int lanes = 1;
  // Link idle, clock parked low between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end
  // Select, a full period ahead of the first rising edge
  task automatic start();
    cs_n = 1'b0;
    #24;
  endtask
  // One byte each way, high bits first
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i >= 0; i -= lanes) begin
      if (lanes == 4) io_in = d[i-:4];
      else if (lanes == 2) io_in = {2'h0, d[i-:2]};
      else io_in = {~io_in[3:1], d[i]};
      #24 sclk = 1'b1;
      if (lanes == 4) q = {q[3:0], io_out};
      else if (lanes == 2) q = {q[5:0], io_out[1:0]};
      else q = {q[6:0], io_out[1]};
      #24 sclk = 1'b0;
    end
  endtask
  // Deselect; lines then toggle so stale data cannot pass
  task automatic stop();
    #24 cs_n = 1'b1;
    io_in = ~io_in;
    #400;
  endtask
endmodule

/* testbench/quad_serial_flash_cmd_decoder_monitor.sv */
/*
  Port checker of the flash command decoder.
  Assumes binding to the decoder top module; all checks on ref_clk.
*/
`timescale 1ns/10ps
module quad_serial_flash_cmd_decoder_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link
  input wire logic cs_n,
  input wire logic [3:0] io_oe,
  // Hand-off
  input wire logic array_busy,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [23:0] cmd_addr,
  input wire logic [8:0] cmd_data_len,
  input wire logic [1:0] sec_reg_sel,
  input wire logic dev_reset,
  // State
  input wire logic write_enable_latch,
  input wire logic four_bit_instruction_mode,
  input wire logic [7:0] status_low_byte,
  input wire logic [7:0] read_parameter_byte
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  valid_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  reset_effect_a: assert property (dev_reset |-> ##[0:2]
    (read_parameter_byte == 8'h40 && !write_enable_latch))
    else $error("device reset left state behind");
  live_bits_a: assert property (
    status_low_byte[1:0] == {write_enable_latch, array_busy})
    else $error("status low bits not live");
  oe_idle_a: assert property (cs_n |-> io_oe == 4'h0)
    else $error("lines driven while deselected");
  // Mode may only move in the gap between frames
  mode_frame_a: assert property ($changed(four_bit_instruction_mode)
    |-> $past(cs_n) && cs_n)
    else $error("mode changed inside a frame");
  erase_latch_a: assert property (cmd_valid && cmd_opcode inside {8'h20, 8'h52, 8'hD8}
    |-> !write_enable_latch && cmd_data_len == 9'h000)
    else $error("erase hand-off wrong");
  prog_len_a: assert property (cmd_valid && cmd_opcode == 8'h02
    |-> cmd_data_len != 9'h000)
    else $error("program with no data");
  sec_sel_a: assert property (cmd_valid && cmd_opcode == 8'h44
    && cmd_addr[23:8] == 16'h0020 |-> sec_reg_sel == 2'h2)
    else $error("security register selection wrong");
  // Main scenarios
  cover property (cmd_valid && cmd_opcode == 8'h02);
  cover property (dev_reset);
  cover property (io_oe == 4'hF);
endmodule
bind quad_serial_flash_cmd_decoder quad_serial_flash_cmd_decoder_monitor mon (.ref_clk, .rst_n,
  .cs_n, .io_oe, .array_busy, .cmd_valid, .cmd_opcode, .cmd_addr, .cmd_data_len,
  .sec_reg_sel, .dev_reset, .write_enable_latch, .four_bit_instruction_mode,
  .status_low_byte, .read_parameter_byte);

/* testbench/tb_quad_serial_flash_cmd_decoder.sv */
/*
  Self-checking bench of the flash command decoder.
  Assumes the host model on the link and a simple array image.
*/
`timescale 1ns/10ps
`include "flash_cmd_params.svh"
module tb_quad_serial_flash_cmd_decoder;
  localparam logic [7:0] MAKER = 8'hC3; // Arbitrary value
  localparam logic [7:0] PART = 8'h96; // Arbitrary value
  localparam logic [7:0] PART_HI = 8'h4B; // Arbitrary value
  // Bench signals and design outputs
  logic ref_clk, rst_n, array_busy, cmd_valid, dev_reset, power_down, sclk, cs_n;
  logic write_enable_latch, four_bit_instruction_mode;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] pg_rd_addr, pg_rd_data, cmd_opcode, arr_data, lock_state_byte;
  logic [7:0] status_low_byte, status_mid_byte, status_high_byte, read_parameter_byte;
  logic [23:0] arr_addr, cmd_addr;
  logic [23:0] valids = 24'h0; // Hand-off strobes seen
  logic [23:0] resets = 24'h0; // Reset strobes seen
  int later = 0; // Lanes after a one-lane opcode, 0 for none
  logic [8:0] cmd_data_len;
  logic [1:0] sec_reg_sel;
  logic [7:0] rx [$];
  int num_errors = 0;
  int compares = 0;
  // Array image: byte is address xor A5h
  assign arr_data = arr_addr[7:0] ^ 8'hA5;
  assign lock_state_byte = arr_addr[15:8];
  quad_serial_flash_cmd_decoder #(.MAKER_CODE(MAKER), .PART_CODE(PART), .PART_CODE_HI(PART_HI))
    dut (.ref_clk, .rst_n, .sclk, .cs_n, .io_in, .io_out, .io_oe, .arr_addr, .arr_data,
    .lock_state_byte, .array_busy, .cmd_valid, .cmd_opcode, .cmd_addr, .cmd_data_len,
    .sec_reg_sel, .pg_rd_addr, .pg_rd_data, .dev_reset, .write_enable_latch,
    .four_bit_instruction_mode, .power_down, .status_low_byte, .status_mid_byte,
    .status_high_byte, .read_parameter_byte);
  flash_host_model host (.sclk, .cs_n, .io_in, .io_out);
  // System clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Count hand-off and reset strobes
  always @(posedge ref_clk) begin
    if (cmd_valid === 1'b1) valids <= valids + 24'h1;
    if (dev_reset === 1'b1) resets <= resets + 24'h1;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Whole frame: bytes out, then n bytes back
  task automatic frame(input logic [7:0] tx [$], input int n);
    logic [7:0] q;
    rx = {};
    host.start();
    foreach (tx[i]) begin
      host.xfer(tx[i], q);
      if (i == 0 && later != 0) host.lanes = later;
    end
    repeat (n) begin
      host.xfer(8'hFF, q);
      rx.push_back(q);
    end
    host.stop();
    if (later != 0) host.lanes = 1;
    @(negedge ref_clk);
  endtask
  task automatic chk_rx(input logic [7:0] e [$]);
    foreach (e[i]) chk(rx[i], e[i]);
  endtask
  task automatic t_latch();
    chk(write_enable_latch, 1'b0);
    frame('{`OP_WREN}, 0);
    chk(write_enable_latch, 1'b1);
    array_busy = 1'b1;
    frame('{`OP_RDSR1}, 2);
    chk_rx('{8'h03, 8'h03});
    array_busy = 1'b0;
    frame('{`OP_WRDI}, 0);
    chk(write_enable_latch, 1'b0);
  endtask
  task automatic t_status();
    frame('{`OP_WREN}, 0);
    frame('{`OP_WRSR1, 8'hA4, 8'h7C}, 0);
    chk(status_low_byte[7:2], 6'h29);
    chk(status_mid_byte, 8'h7C);
    frame('{`OP_VWREN}, 0);
    frame('{`OP_WRSR3, 8'h5A}, 0);
    chk(status_high_byte, 8'h5A);
    frame('{`OP_RDSR3}, 2);
    chk_rx('{8'h5A, 8'h5A});
  endtask
  task automatic t_prog();
    logic [23:0] v;
    v = valids;
    frame('{`OP_PP, 8'h01, 8'h23, 8'h00, 8'h11}, 0);
    chk(valids, v);
    frame('{`OP_WREN}, 0);
    frame('{`OP_PP, 8'h01, 8'h23, 8'h00, 8'h11, 8'h22, 8'h33}, 0);
    chk(valids, v + 24'h1);
    chk(cmd_addr, 24'h012300);
    chk(cmd_data_len, 9'h003);
    pg_rd_addr = 8'h01;
    repeat (2) @(negedge ref_clk);
    chk(pg_rd_data, 8'h22);
  endtask
  // Every erase, lock, suspend and resume command; 44h last for the selector
  task automatic t_erase();
    logic [7:0] ops [12] = '{8'h20, 8'h52, 8'hD8, 8'h36, 8'h39, 8'hC7, 8'h60, 8'h75,
      8'h7A, 8'h7E, 8'h98, 8'h44};
    foreach (ops[i]) begin
      frame('{`OP_WREN}, 0);
      if (i < 5 || i == 11) frame('{ops[i], 8'h00, 8'h20, 8'h00}, 0);
      else frame('{ops[i]}, 0);
      chk(cmd_opcode, ops[i]);
    end
    chk(sec_reg_sel, 2'h2);
    frame('{`OP_RD_LOCK, 8'h00, 8'h5C, 8'h00}, 2);
    chk_rx('{8'h5C, 8'h5C});
  endtask
  // Opcode on one lane, the rest on two or four; parameter still at reset
  task automatic t_wide();
    later = 2;
    frame('{`OP_DIO_RD, 8'h00, 8'h02, 8'h10, 8'h00}, 1);
    chk_rx('{8'hB5});
    later = 4;
    frame('{`OP_WORD_RD, 8'h00, 8'h02, 8'h10, 8'h00, 8'h00}, 1);
    chk_rx('{8'hB5});
    later = 0;
  endtask
  task automatic t_quad();
    frame('{`OP_MODE_ENTER}, 0);
    host.lanes = 4;
    frame('{`OP_SETP, 8'h20}, 0);
    chk(read_parameter_byte, 8'h20);
    frame('{`OP_JEDEC}, 3);
    chk_rx('{MAKER, PART_HI, PART});
    frame('{`OP_FREAD, 8'h00, 8'h01, 8'h07, 8'h00}, 2);
    chk_rx('{8'hA2, 8'hAD});
    frame('{`OP_WRAP_RD, 8'h00, 8'h01, 8'h07, 8'h00}, 2);
    chk_rx('{8'hA2, 8'hA5});
    frame('{`OP_QIO_RD, 8'h00, 8'h02, 8'h10, 8'h00, 8'h00}, 1);
    chk_rx('{8'hB5});
    frame('{`OP_OCT_RD, 8'h00, 8'h02, 8'h10, 8'h00}, 1);
    chk_rx('{8'hB5});
    frame('{`OP_MODE_EXIT}, 0);
    host.lanes = 1;
    chk(four_bit_instruction_mode, 1'b0);
  endtask
  task automatic t_reset();
    logic [23:0] v;
    v = resets;
    frame('{`OP_RST_DEV}, 0);
    chk(resets, v);
    frame('{`OP_RST_EN}, 0);
    frame('{`OP_RST_DEV}, 0);
    chk(resets, v + 24'h1);
    frame('{`OP_PDOWN}, 0);
    chk(power_down, 1'b1);
    frame('{`OP_WREN}, 0);
    chk(write_enable_latch, 1'b0);
    frame('{`OP_RELPD, 8'h00, 8'h00, 8'h00}, 2);
    chk_rx('{PART, PART});
    frame('{`OP_MFID, 8'h00, 8'h00, 8'h00}, 2);
    chk_rx('{MAKER, PART});
  endtask
  task automatic conclude();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #2000000;
    num_errors++;
    conclude();
  end
  initial begin
    array_busy = 1'b0;
    pg_rd_addr = 8'h00;
    rst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_latch();
    t_status();
    t_prog();
    t_erase();
    t_wide();
    t_quad();
    t_reset();
    conclude();
  end
endmodule
